/* File: design/pdh_pkg.sv */
// Constants and state type for the pin sleep hold block.
// Assumes a single 100 MHz clock domain.
package pdh_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WAKE_MAX_NS = 1000;
  // Longest time, so round down
  localparam int WAKE_MAX_CYC = T_WAKE_MAX_NS / CLK_PERIOD_NS;
  // Synchroniser, state and output flop latency eaten from the budget
  localparam int WAKE_OVERHEAD_CYC = 8;
  localparam int RESUME_CYC = WAKE_MAX_CYC - WAKE_OVERHEAD_CYC;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] RESUME_CNT = CNT_W'(RESUME_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

  // Default pin group width
  localparam int PIN_W_DEF = 8;

  typedef enum logic [1:0] {
    PDH_RUN = 2'b00,
    PDH_SLEEP = 2'b01,
    PDH_WAKE = 2'b10
  } pdh_state_t;

endpackage : pdh_pkg

/* File: design/pdh_hold_bank.sv */
// Per-bit hold register bank: follows its input, freezes while held.
// Assumes hold_i and d_i come from the same clock domain.
`timescale 1ns/100ps
module pdh_hold_bank #(
  parameter int W = pdh_pkg::PIN_W_DEF
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hold_i,
  input wire logic [W-1:0] rst_val_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import pdh_pkg::*;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // Reset value taken on first clocked cycle, not under async reset
      logic seeded;
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          seeded <= 1'b0;
        end else begin
          seeded <= 1'b1;
        end
      end
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          q_o[g] <= 1'b0;
        end else if (!seeded) begin
          q_o[g] <= rst_val_i[g];
        end else if (!hold_i) begin
          q_o[g] <= d_i[g];
        end
      end
    end
  endgenerate

endmodule : pdh_hold_bank

/* File: design/pdh_top.sv */
// Pin-controlled sleep and hold logic between core logic and pins.
// Assumes sleep_en_i and keeper_en_i are static configuration bits
// on mclk_i; the request and data pins are asynchronous.
`timescale 1ns/100ps
module pdh_top #(
  parameter int W = pdh_pkg::PIN_W_DEF
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sleep_en_i,
  input wire logic keeper_en_i,
  input wire logic sleep_request_pin_a_i,
  input wire logic sleep_request_pin_b_i,
  input wire logic [W-1:0] pin_in_i,
  input wire logic [W-1:0] core_out_i,
  input wire logic [W-1:0] core_oe_i,
  output logic [W-1:0] pin_out_o,
  output logic [W-1:0] pin_oe_o,
  output logic [W-1:0] core_in_o,
  output logic core_run_o,
  output logic asleep_o,
  output logic pin_keep_o,
  output logic req_a_in_o,
  output logic req_b_in_o
);
  import pdh_pkg::*;

  // Reset release synchroniser
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Pin synchronisers; first stages read only by second stages
  logic req_a_q1;
  logic req_a_q2;
  logic req_b_q1;
  logic req_b_q2;
  logic [W-1:0] pin_q1;
  logic [W-1:0] pin_q2;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_a_q1 <= 1'b0;
      req_a_q2 <= 1'b0;
      req_b_q1 <= 1'b0;
      req_b_q2 <= 1'b0;
      pin_q1 <= '0;
      pin_q2 <= '0;
    end else begin
      req_a_q1 <= sleep_request_pin_a_i;
      req_a_q2 <= req_a_q1;
      req_b_q1 <= sleep_request_pin_b_i;
      req_b_q2 <= req_b_q1;
      pin_q1 <= pin_in_i;
      pin_q2 <= pin_q1;
    end
  end

  // Either pin requests sleep, only with the feature configured
  logic sleep_req;
  assign sleep_req = sleep_en_i & (req_a_q2 | req_b_q2);

  pdh_state_t state;
  pdh_state_t next_state;
  logic [CNT_W-1:0] wake_cnt;

  always_comb begin
    next_state = state;
    unique case (state)
      PDH_RUN: begin
        if (sleep_req) begin
          next_state = PDH_SLEEP;
        end
      end
      PDH_SLEEP: begin
        if (!sleep_req) begin
          next_state = PDH_WAKE;
        end
      end
      PDH_WAKE: begin
        // A fresh request during recovery goes straight back to sleep
        if (sleep_req) begin
          next_state = PDH_SLEEP;
        end else if (wake_cnt == CNT_ZERO) begin
          next_state = PDH_RUN;
        end
      end
      default: begin
        next_state = PDH_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= PDH_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Recovery counter, bounded so resume lands inside the wake budget
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt <= CNT_ZERO;
    end else if (next_state == PDH_WAKE && state != PDH_WAKE) begin
      wake_cnt <= RESUME_CNT;
    end else if (wake_cnt != CNT_ZERO) begin
      wake_cnt <= wake_cnt - CNT_ONE;
    end
  end

  // Hold as soon as the request is seen, before the state flop moves
  logic hold;
  assign hold = sleep_req | (state != PDH_RUN);

  // Core clock enable; core registers stay frozen, so resume is lossless
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      core_run_o <= 1'b0;
      asleep_o <= 1'b0;
      pin_keep_o <= 1'b0;
    end else begin
      core_run_o <= (next_state == PDH_RUN) && !sleep_req;
      asleep_o <= (next_state != PDH_RUN);
      pin_keep_o <= keeper_en_i | (next_state != PDH_RUN);
    end
  end

  // Sleep pins reach the core only when not dedicated to sleep
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_a_in_o <= 1'b0;
      req_b_in_o <= 1'b0;
    end else begin
      req_a_in_o <= req_a_q2 & ~sleep_en_i;
      req_b_in_o <= req_b_q2 & ~sleep_en_i;
    end
  end

  // Output data, output enables and input view all frozen on hold
  pdh_hold_bank #(.W(W)) u_out_bank (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .hold_i(hold),
    .rst_val_i({W{1'b0}}),
    .d_i(core_out_i),
    .q_o(pin_out_o)
  );

  pdh_hold_bank #(.W(W)) u_oe_bank (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .hold_i(hold),
    .rst_val_i({W{1'b0}}),
    .d_i(core_oe_i),
    .q_o(pin_oe_o)
  );

  // Input hold latch keeps the last level while pins are blocked
  pdh_hold_bank #(.W(W)) u_in_bank (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .hold_i(hold),
    .rst_val_i({W{1'b0}}),
    .d_i(pin_q2),
    .q_o(core_in_o)
  );

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  property p_enter;
    sleep_req |=> asleep_o && !core_run_o;
  endproperty
  a_enter: assert property (p_enter)
    else $error("sleep request did not put block asleep");

  property p_pin_dedicated;
    sleep_en_i |=> !req_a_in_o && !req_b_in_o;
  endproperty
  a_pin_dedicated: assert property (p_pin_dedicated)
    else $error("sleep pin leaked into core while dedicated");

  property p_out_held;
    asleep_o && $past(asleep_o) |-> $stable(pin_out_o);
  endproperty
  a_out_held: assert property (p_out_held)
    else $error("output changed while asleep");

  // No enable bit that was off may turn on while asleep, any bit
  property p_hiz_held;
    asleep_o && $past(asleep_o) |-> (pin_oe_o & ~$past(pin_oe_o)) == '0;
  endproperty
  a_hiz_held: assert property (p_hiz_held)
    else $error("high impedance output enabled during sleep");

  property p_in_blocked;
    asleep_o && $past(asleep_o) |-> $stable(core_in_o);
  endproperty
  a_in_blocked: assert property (p_in_blocked)
    else $error("input view changed while asleep");

  property p_keeper;
    asleep_o |-> pin_keep_o;
  endproperty
  a_keeper: assert property (p_keeper)
    else $error("hold latch inactive during sleep");

  property p_disabled;
    !sleep_en_i && !$past(sleep_en_i, 2) && state == PDH_RUN
      |=> state == PDH_RUN;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("sleep entered with feature disabled");

  property p_wake_out;
    $fell(req_a_q2 | req_b_q2) && state == PDH_SLEEP
      |-> ##[1:96] (core_run_o || sleep_req);
  endproperty
  a_wake_out: assert property (p_wake_out)
    else $error("outputs not released within wake budget");

  property p_wake_min;
    $rose(state == PDH_WAKE) |-> (!core_run_o || sleep_req) [*8];
  endproperty
  a_wake_min: assert property (p_wake_min)
    else $error("core resumed too early after sleep");

  property p_frozen;
    state != PDH_RUN |=> !core_run_o || $past(state) == PDH_WAKE;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("core clocked while held");

  c_sleep: cover property (state == PDH_RUN ##1 state == PDH_SLEEP);
  c_wake: cover property (state == PDH_WAKE ##1 state == PDH_RUN);
  c_resleep: cover property (state == PDH_WAKE ##1 state == PDH_SLEEP);

endmodule : pdh_top

/* File: verif/pdh_sleep_src.sv */
// External logic that drives the two sleep request pins.
// Assumes the bench calls its tasks; pins move at falling edges.
`timescale 1ns/100ps
module pdh_sleep_src (
  input wire logic mclk_i,
  output logic req_a_o,
  output logic req_b_o
);
  initial begin
    req_a_o = 1'b0;
    req_b_o = 1'b0;
  end

  // Pins carry sleep requests, or logic data to the core while sleep is not enabled
  task automatic raise(input logic sel);
    @(negedge mclk_i);
    if (sel) begin
      req_b_o = 1'b1;
    end else begin
      req_a_o = 1'b1;
    end
  endtask : raise

  task automatic drop();
    @(negedge mclk_i);
    req_a_o = 1'b0;
    req_b_o = 1'b0;
  endtask : drop
endmodule : pdh_sleep_src

/* File: verif/tb_pin_power_down_hold.sv */
// Self-checking bench for the pin sleep hold block.
// Assumes pdh_top with W of 8 and the partner model beside it.
`timescale 1ns/100ps
module tb_pin_power_down_hold;
  logic mclk, rst_n, sleep_en, keeper_en, req_a, req_b;
  logic [7:0] pin_in, core_out, core_oe, pin_out, pin_oe, core_in;
  logic core_run, asleep, pin_keep, req_a_in, req_b_in;
  int fail_count = 0;
  int tests_run = 0;

  pdh_top #(.W(8)) dut (.mclk_i(mclk), .rst_n_i(rst_n),
    .sleep_en_i(sleep_en), .keeper_en_i(keeper_en),
    .sleep_request_pin_a_i(req_a), .sleep_request_pin_b_i(req_b),
    .pin_in_i(pin_in), .core_out_i(core_out), .core_oe_i(core_oe),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .core_in_o(core_in),
    .core_run_o(core_run), .asleep_o(asleep), .pin_keep_o(pin_keep),
    .req_a_in_o(req_a_in), .req_b_in_o(req_b_in));

  pdh_sleep_src src (.mclk_i(mclk), .req_a_o(req_a), .req_b_o(req_b));

  always #5 mclk = ~mclk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Config bits are static, so each change goes under reset
  task automatic do_reset(input logic en, input logic keep);
    @(negedge mclk);
    sleep_en = en;
    keeper_en = keep;
    rst_n = 1'b0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask : do_reset

  task automatic set_in(input logic [7:0] co, oe, pi);
    @(negedge mclk);
    core_out = co;
    core_oe = oe;
    pin_in = pi;
  endtask : set_in

  // Feature off, keepers configured on while awake
  task automatic t_off();
    do_reset(1'b0, 1'b1);
    set_in(8'h5A, 8'hFF, 8'hC3);
    src.raise(1'b0);
    src.raise(1'b1);
    repeat (6) @(negedge mclk);
    chk({7'h00, asleep}, 8'h00);
    chk({7'h00, core_run}, 8'h01);
    chk({7'h00, req_a_in}, 8'h01);
    chk({7'h00, req_b_in}, 8'h01);
    chk({7'h00, pin_keep}, 8'h01);
    chk(pin_out, 8'h5A);
    chk(core_in, 8'hC3);
    src.drop();
  endtask : t_off

  task automatic t_sleep(input logic sel, input int hold, input logic rearm);
    int n;
    do_reset(1'b1, 1'b0);
    set_in(8'hA5, 8'h0F, 8'h3C);
    repeat (4) @(negedge mclk);
    chk(pin_out, 8'hA5);
    chk({7'h00, pin_keep}, 8'h00);
    src.raise(sel);
    repeat (4) @(negedge mclk);
    chk({7'h00, asleep}, 8'h01);
    chk({7'h00, core_run}, 8'h00);
    chk({6'h00, req_a_in, req_b_in}, 8'h00);
    set_in(8'h11, 8'hF0, 8'hE7);
    repeat (hold) @(negedge mclk);
    chk(pin_out, 8'hA5);
    chk(pin_oe, 8'h0F);
    chk(core_in, 8'h3C);
    chk({7'h00, pin_keep}, 8'h01);
    src.drop();
    if (rearm) begin
      // Request again while recovering: must fall back asleep
      repeat (20) @(negedge mclk);
      src.raise(~sel);
      repeat (4) @(negedge mclk);
      chk({7'h00, asleep}, 8'h01);
      chk(pin_out, 8'hA5);
      src.drop();
    end
    // Outputs must show new core data within 100 cycles of the fall
    n = 0;
    while (pin_out !== 8'h11 && n < 150) begin
      @(negedge mclk);
      n++;
    end
    chk({7'h00, n <= 100}, 8'h01);
    chk({7'h00, asleep}, 8'h00);
    repeat (4) @(negedge mclk);
    chk({7'h00, core_run}, 8'h01);
    chk(pin_out, 8'h11);
    chk(pin_oe, 8'hF0);
    chk(core_in, 8'hE7);
  endtask : t_sleep

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    sleep_en = 1'b0;
    keeper_en = 1'b0;
    pin_in = 8'h00;
    core_out = 8'h00;
    core_oe = 8'h00;
    t_off();
    t_sleep(1'b0, 3, 1'b0);
    t_sleep(1'b1, 60, 1'b1);
    finish_test();
  end

  // Whole run is a few hundred cycles; this is a wide margin
  initial begin
    #100us;
    fail_count++;
    finish_test();
  end
endmodule : tb_pin_power_down_hold
